// ### rtl/irq_ctrl_pkg.sv
// constants and carrier types for the two level interrupt controller
package irq_ctrl_pkg;
  localparam int SOURCES = 19;
  localparam int IDX_W   = 5;

  // register offsets
  localparam logic [7:0] PRIMARY_MASK_OFS = 8'h00;
  localparam logic [7:0] EXT_MASK1_OFS    = 8'h01;
  localparam logic [7:0] EXT_MASK2_OFS    = 8'h02;
  localparam logic [7:0] PRIMARY_PRIO_OFS = 8'h03;
  localparam logic [7:0] EXT_PRIO1_OFS    = 8'h04;
  localparam logic [7:0] EXT_PRIO2_OFS    = 8'h05;
  localparam logic [7:0] PENDING0_OFS     = 8'h06;
  localparam logic [7:0] PENDING1_OFS     = 8'h07;
  localparam logic [7:0] PENDING2_OFS     = 8'h08;
  localparam logic [7:0] AUX_ENABLE_OFS   = 8'h09;
  localparam logic [7:0] EVENT_STATUS_OFS = 8'h0A;
  localparam logic [7:0] EVENT_MASK_OFS   = 8'h0B;
  localparam logic [7:0] SERVICE_OFS      = 8'h0C;

  // field positions
  localparam int GLOBAL_ENABLE_BIT = 7;
  localparam int EXT1_BASE         = 7;
  localparam int EXT2_BASE         = 15;

  // reset values
  localparam logic [7:0] MASK_RESET      = 8'h00;
  localparam logic [7:0] PRIO_RESET      = 8'h00;
  localparam logic [7:0] PRIO_RSVD_READ  = 8'h80;
  localparam logic [7:0] AUX_RESET       = 8'h00;
  localparam logic [18:0] PENDING_RESET  = 19'h0_0000;

  // sources whose flag clears when the cpu vectors
  localparam logic [18:0] AUTO_CLEAR = 19'h0_000F;

  // auxiliary enable bit to source index
  localparam int AUX_COUNT = 5;
  localparam logic [IDX_W-1:0] AUX_SRC [AUX_COUNT] =
    '{5'h05, 5'h0B, 5'h0C, 5'h0D, 5'h0E};

  // handler addresses
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_BASE  = 16'h0003;
  localparam logic [15:0] VECTOR_STEP  = 16'h0008;
  localparam logic [15:0] VECTOR_LAST  = 16'h0093;

  // timing in system clock cycles
  localparam int DETECT_CYCLES  = 1;
  localparam int CALL_CYCLES    = 4;
  localparam int RETURN_CYCLES  = 5;
  localparam int LONGEST_INSTR  = 8;
  localparam int BEST_RESPONSE  = DETECT_CYCLES + CALL_CYCLES;
  localparam int WORST_RESPONSE = DETECT_CYCLES + RETURN_CYCLES
                                  + LONGEST_INSTR + CALL_CYCLES;

  // event status bits
  localparam int EV_VECTOR = 0;
  localparam int EV_RETURN = 1;
  localparam int EV_HELD   = 2;

  typedef struct packed {
    logic             valid;
    logic             high;
    logic [IDX_W-1:0] source;
    logic [15:0]      vector;
  } call_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } reg_req_type;
endpackage

// ### rtl/irq_ctrl.sv
// two level interrupt controller: masks, priorities, vectoring
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (R1) flag sets on event even if disabled
// (R2) enabled pending flag raises request, vector after instruction
// (R3) long call to fixed slot per source
// (R4) handler ends with return, resumes program
// (R5) disabled source pending flag is ignored
// (R6) per source enable gates its request
// (R7) global enable off blocks every source
// (R8) some flags clear on vector, rest software
// (R9) flag still set after return requests again
// (R10) software write of one acts as event
// (R11) two levels, high preempts low only
// (R12) priorities reset to low
// (R13) high level wins, then lower index
// (R14) sample every cycle, five cycle best case
// (R15) one instruction after return before call
// (R16) worst response at most eighteen cycles
// (R17) equal or lower level waits for return
// (R18) best pending chosen on handler exit
// (R19) auxiliary enable also needed where present
module irq_ctrl
  import irq_ctrl_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire reg_req_type        reg_req_i,
  output var  logic [7:0]         reg_rdata_o,
  input  wire logic [SOURCES-1:0] source_event_i,
  input  wire logic               instr_done_i,
  input  wire logic               return_done_i,
  output var  logic               request_o,
  output var  call_type           call_o,
  output var  logic               irq_o
);

  // ****************************************
  // functions
  // ****************************************
  // lowest set index of a request vector
  function automatic logic [IDX_W:0] pick(input logic [SOURCES-1:0] v);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = SOURCES - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] vector_of(input logic [IDX_W-1:0] s);
    return VECTOR_BASE + VECTOR_STEP * {11'h000, s};
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]         primary_mask_register;
  logic [15:0]        extended_mask_registers;
  logic [6:0]         primary_priority_register;
  logic [15:0]        extended_priority_registers;
  logic [SOURCES-1:0] pending;
  logic [AUX_COUNT-1:0] aux_enable;
  logic [2:0]         event_status;
  logic [2:0]         event_mask;
  logic               in_high;
  logic               in_low;
  logic [IDX_W-1:0]   last_source;

  logic               global_interrupt_enable;
  logic [SOURCES-1:0] source_enable;
  logic [SOURCES-1:0] source_high;
  logic [SOURCES-1:0] aux_ok;
  logic [SOURCES-1:0] eligible;
  logic [IDX_W:0]     best_high;
  logic [IDX_W:0]     best_low;
  logic               take_high;
  logic               take_low;
  logic               take;
  logic [IDX_W-1:0]   take_src;
  logic               wr;
  logic               rd;
  logic [SOURCES-1:0] sw_set;
  logic [SOURCES-1:0] sw_clr;
  logic [SOURCES-1:0] auto_clr;
  logic [2:0]         next_event;

  assign wr = reg_req_i.write;
  assign rd = reg_req_i.read;
  assign global_interrupt_enable = primary_mask_register[GLOBAL_ENABLE_BIT];
  assign source_enable = {extended_mask_registers[11:0],
                          primary_mask_register[6:0]};
  assign source_high   = {extended_priority_registers[11:0],
                          primary_priority_register};

  always_comb
  begin
    aux_ok = '1;
    // (R19) auxiliary gate
    for (int k = 0; k < AUX_COUNT; k++)
    begin
      aux_ok[AUX_SRC[k]] = aux_enable[k];
    end
  end

  // (R5) disabled flags ignored, (R6) (R7) enable gating
  assign eligible  = pending & source_enable & aux_ok
                     & {SOURCES{global_interrupt_enable}};
  // (R13) level first, then vector index
  assign best_high = pick(eligible & source_high);
  assign best_low  = pick(eligible & ~source_high);
  // (R11) (R17) only a higher level preempts
  assign take_high = best_high[IDX_W] && !in_high;
  assign take_low  = !best_high[IDX_W] && best_low[IDX_W]
                     && !in_high && !in_low;
  // (R2) (R15) (R16) vector only at a non-return instruction end
  assign take      = (take_high || take_low) && instr_done_i
                     && !return_done_i;
  assign take_src  = take_high ? best_high[IDX_W-1:0]
                               : best_low[IDX_W-1:0];

  // ****************************************
  // mask and priority registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      primary_mask_register   <= MASK_RESET;
      extended_mask_registers <= {MASK_RESET, MASK_RESET};
      aux_enable              <= AUX_RESET[AUX_COUNT-1:0];
      event_mask              <= MASK_RESET[2:0];
    end
    else if (wr)
    begin
      if (reg_req_i.addr == PRIMARY_MASK_OFS)
        primary_mask_register <= reg_req_i.wdata;
      if (reg_req_i.addr == EXT_MASK1_OFS)
        extended_mask_registers[7:0] <= reg_req_i.wdata;
      if (reg_req_i.addr == EXT_MASK2_OFS)
        extended_mask_registers[15:8] <= {4'h0, reg_req_i.wdata[3:0]};
      if (reg_req_i.addr == AUX_ENABLE_OFS)
        aux_enable <= reg_req_i.wdata[AUX_COUNT-1:0];
      if (reg_req_i.addr == EVENT_MASK_OFS)
        event_mask <= reg_req_i.wdata[2:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    // (R12) low level after reset
    if (reset_i)
    begin
      primary_priority_register   <= PRIO_RESET[6:0];
      extended_priority_registers <= {PRIO_RESET, PRIO_RESET};
    end
    else if (wr)
    begin
      if (reg_req_i.addr == PRIMARY_PRIO_OFS)
        primary_priority_register <= reg_req_i.wdata[6:0];
      if (reg_req_i.addr == EXT_PRIO1_OFS)
        extended_priority_registers[7:0] <= reg_req_i.wdata;
      if (reg_req_i.addr == EXT_PRIO2_OFS)
        extended_priority_registers[15:8] <= {4'h0, reg_req_i.wdata[3:0]};
    end
  end

  // ****************************************
  // pending flags
  // ****************************************
  always_comb
  begin
    sw_set = '0;
    sw_clr = '0;
    if (wr && reg_req_i.addr == PENDING0_OFS)
    begin
      sw_set[6:0] = reg_req_i.wdata[6:0];
      sw_clr[6:0] = ~reg_req_i.wdata[6:0];
    end
    if (wr && reg_req_i.addr == PENDING1_OFS)
    begin
      sw_set[14:7] = reg_req_i.wdata;
      sw_clr[14:7] = ~reg_req_i.wdata;
    end
    if (wr && reg_req_i.addr == PENDING2_OFS)
    begin
      sw_set[18:15] = reg_req_i.wdata[3:0];
      sw_clr[18:15] = ~reg_req_i.wdata[3:0];
    end
    auto_clr = '0;
    // (R8) hardware clear on vector for some sources
    if (take)
      auto_clr[take_src] = AUTO_CLEAR[take_src];
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pending <= PENDING_RESET;
    else
      // (R1) (R10) events and software ones win over clears
      pending <= (pending & ~sw_clr & ~auto_clr) | source_event_i | sw_set;
  end

  // ****************************************
  // vectoring and service levels
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      call_o    <= '0;
      request_o <= 1'b0;
    end
    else
    begin
      // (R14) sampled and decoded every cycle
      request_o     <= take_high || take_low;
      // (R3) fixed slot per source
      call_o.valid  <= take;
      call_o.high   <= take_high;
      call_o.source <= take ? take_src : call_o.source;
      call_o.vector <= take ? vector_of(take_src) : call_o.vector;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      in_high     <= 1'b0;
      in_low      <= 1'b0;
      last_source <= '0;
    end
    else if (take)
    begin
      in_high     <= in_high | take_high;
      in_low      <= in_low | !take_high;
      last_source <= take_src;
    end
    // (R4) (R9) (R18) return drops the active level
    else if (return_done_i)
    begin
      if (in_high)
        in_high <= 1'b0;
      else
        in_low <= 1'b0;
    end
  end

  // ****************************************
  // own interrupt and read port
  // ****************************************
  always_comb
  begin
    next_event = event_status;
    if (rd && reg_req_i.addr == EVENT_STATUS_OFS)
      next_event = '0;
    next_event[EV_VECTOR] = next_event[EV_VECTOR] | take;
    next_event[EV_RETURN] = next_event[EV_RETURN] | return_done_i;
    next_event[EV_HELD]   = next_event[EV_HELD]
                            | (instr_done_i && |eligible && !take);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      event_status <= '0;
      irq_o        <= 1'b0;
    end
    else
    begin
      event_status <= next_event;
      irq_o        <= |(next_event & event_mask);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      reg_rdata_o <= 8'h00;
    else if (rd)
    begin
      unique case (reg_req_i.addr)
        PRIMARY_MASK_OFS: reg_rdata_o <= primary_mask_register;
        EXT_MASK1_OFS:    reg_rdata_o <= extended_mask_registers[7:0];
        EXT_MASK2_OFS:    reg_rdata_o <= extended_mask_registers[15:8];
        PRIMARY_PRIO_OFS: reg_rdata_o <= PRIO_RSVD_READ
                                         | {1'b0, primary_priority_register};
        EXT_PRIO1_OFS:    reg_rdata_o <= extended_priority_registers[7:0];
        EXT_PRIO2_OFS:    reg_rdata_o <= extended_priority_registers[15:8];
        PENDING0_OFS:     reg_rdata_o <= {1'b0, pending[6:0]};
        PENDING1_OFS:     reg_rdata_o <= pending[14:7];
        PENDING2_OFS:     reg_rdata_o <= {4'h0, pending[18:15]};
        AUX_ENABLE_OFS:   reg_rdata_o <= {3'h0, aux_enable};
        EVENT_STATUS_OFS: reg_rdata_o <= {5'h00, event_status};
        EVENT_MASK_OFS:   reg_rdata_o <= {5'h00, event_mask};
        SERVICE_OFS:      reg_rdata_o <= {in_high, in_low, 1'b0, last_source};
        default:          reg_rdata_o <= 8'h00;
      endcase
    end
    else
      reg_rdata_o <= 8'h00;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_event_sets_flag: assert property ( // (R1)
    |source_event_i |=> (pending & $past(source_event_i)) == $past(source_event_i))
    else $error("event did not set its pending flag");

  a_global_blocks: assert property ( // (R7)
    !global_interrupt_enable |=> !call_o.valid)
    else $error("call issued with global enable off");

  a_call_on_boundary: assert property ( // (R2)
    call_o.valid |-> $past(instr_done_i) && !$past(return_done_i))
    else $error("call not at an instruction end");

  a_vector_slot: assert property ( // (R3)
    call_o.valid |-> call_o.vector == vector_of(call_o.source)
                     && call_o.vector <= VECTOR_LAST)
    else $error("vector address wrong");

  a_call_source_ok: assert property ( // (R6)
    call_o.valid |-> $past(take) && $past(take_src) == call_o.source
                     && $past(source_enable[take_src]))
    else $error("disabled source vectored");

  a_no_preempt_high: assert property ( // (R11)
    in_high && !return_done_i |=> !call_o.valid)
    else $error("high level handler preempted");

  a_high_wins: assert property ( // (R13)
    take && best_high[IDX_W] |-> take_src == best_high[IDX_W-1:0])
    else $error("low level chosen over high");

  a_auto_clear: assert property ( // (R8)
    take && take_src == 5'h00 && !source_event_i[0] && !sw_set[0]
    |=> !pending[0])
    else $error("auto clear flag stayed set");

  a_prio_reset: assert property ( // (R12)
    $fell(reset_i) |-> source_high == '0)
    else $error("priority not low after reset");

  c_simple_call: cover property (take ##1 call_o.valid);
  c_preempt: cover property (in_low && take_high);
  c_reentry: cover property (return_done_i ##[1:8] take);

endmodule

`default_nettype wire

// ### test/cpu_model.sv
// behavioural cpu sequencer that consumes calls from the controller
`timescale 1ns/1ps
`default_nettype none
module cpu_model
  import irq_ctrl_pkg::*;
#(
  parameter int ILEN = 2,
  parameter int HLEN = 6
)
(
  input  wire logic     clk_i,
  input  wire logic     reset_i,
  input  wire call_type call_i,
  output var  logic     instr_done_o,
  output var  logic     return_done_o,
  output var  int       depth_o
);
  // ***************************************************
  // instruction boundaries, calls and returns
  // ***************************************************
  int tick;
  int stall;
  int left [4];

  always_ff @(posedge clk_i)
  begin
    instr_done_o  <= 1'b0;
    return_done_o <= 1'b0;
    if (reset_i)
    begin
      tick    <= ILEN - 1;
      stall   <= 0;
      depth_o <= 0;
    end
    else if (call_i.valid)
    begin
      stall         <= CALL_CYCLES - 1;
      left[depth_o] <= HLEN;
      depth_o       <= depth_o + 1;
      tick          <= ILEN - 1;
    end
    else if (stall > 0)
      stall <= stall - 1;
    else if (tick > 0)
      tick <= tick - 1;
    else if (depth_o > 0 && left[depth_o - 1] == 0)
    begin
      return_done_o <= 1'b1;
      depth_o       <= depth_o - 1;
      tick          <= ILEN - 1;
    end
    else
    begin
      instr_done_o <= 1'b1;
      tick         <= ILEN - 1;
      if (depth_o > 0)
      begin
        left[depth_o - 1] <= left[depth_o - 1] - 1;
        if (left[depth_o - 1] == 1)
          tick <= RETURN_CYCLES - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/irq_ctrl_tb.sv
// self-checking bench for the two level interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_tb import irq_ctrl_pkg::*;;
  // ***************************************************
  // signals, instances, clock and monitor
  // ***************************************************
  localparam int ILEN = 2;
  logic               clk_i;
  logic               reset_i;
  reg_req_type        req;
  logic [7:0]         rdata;
  logic [SOURCES-1:0] ev;
  logic               idone;
  logic               rdone;
  logic               request;
  call_type           call;
  logic               irq;
  int                 depth;
  int                 lat;
  int                 cycles = 0;
  int                 miscompares = 0;
  int                 cmp_count = 0;
  call_type           calls [$];
  logic [7:0]         v;

  irq_ctrl u_dut (
    .clk_i          (clk_i),
    .reset_i        (reset_i),
    .reg_req_i      (req),
    .reg_rdata_o    (rdata),
    .source_event_i (ev),
    .instr_done_i   (idone),
    .return_done_i  (rdone),
    .request_o      (request),
    .call_o         (call),
    .irq_o          (irq)
  );
  cpu_model #(.ILEN(ILEN)) u_cpu (
    .clk_i         (clk_i),
    .reset_i       (reset_i),
    .call_i        (call),
    .instr_done_o  (idone),
    .return_done_o (rdone),
    .depth_o       (depth)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (call.valid === 1'b1)
      calls.push_back(call);
    if (cycles == 5000)
    begin
      miscompares++;
      stop_test();
    end
  end
  // ***************************************************
  // access tasks
  // ***************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    req <= '0;
    #1 v = rdata;
  endtask
  task automatic pend(input int s, input logic on);
    logic [7:0] a;
    int         b;
    a = s < EXT1_BASE ? PENDING0_OFS : PENDING1_OFS;
    a = s < EXT2_BASE ? a : PENDING2_OFS;
    b = s < EXT1_BASE ? s : s - EXT1_BASE;
    b = s < EXT2_BASE ? b : s - EXT2_BASE;
    wr(a, on ? 8'(1 << b) : 8'h00);
  endtask
  task automatic fire(input int s);
    @(posedge clk_i);
    ev[s] <= 1'b1;
    @(posedge clk_i);
    ev <= '0;
  endtask
  task automatic wait_call(input int s, input logic hi, input int lim);
    call_type c;
    logic [15:0] vec;
    lat = 0;
    while (calls.size() == 0 && lat < lim)
    begin
      @(posedge clk_i);
      #1 lat++;
    end
    c = calls.size() > 0 ? calls.pop_front() : '0;
    vec = VECTOR_BASE + VECTOR_STEP * 16'(s);
    check({c.valid, c.high, c.source, c.vector}, {1'b1, hi, 5'(s), vec});
  endtask
  task automatic drain();
    for (int n = 0; n < 300 && depth != 0; n++)
      @(posedge clk_i);
    #1;
  endtask
  task automatic idle();
    drain();
    repeat (2 * ILEN) @(posedge clk_i);
  endtask
  task automatic quiet(input int n);
    repeat (n) @(posedge clk_i);
    #1 check(calls.size(), 0);
  endtask
  // ***************************************************
  // test sequence
  // ***************************************************
  initial
  begin
    reset_i = 1'b1;
    req = '0;
    ev = '0;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1 check(irq, 1'b0);
    for (int a = 0; a <= 13; a++)
    begin
      rd(8'(a));
      check(v, 8'(a) == PRIMARY_PRIO_OFS ? PRIO_RSVD_READ : 8'h00);
    end
    fire(1);
    rd(PENDING0_OFS);
    check(v, 8'h02);
    quiet(20);
    wr(PRIMARY_MASK_OFS, 8'h02);
    quiet(20);
    check(request, 1'b0);
    wr(PRIMARY_MASK_OFS, 8'h82);
    wait_call(1, 1'b0, 20);
    rd(PENDING0_OFS);
    check(v, 8'h00);
    idle();
    fire(1);
    wait_call(1, 1'b0, 20);
    check(lat <= DETECT_CYCLES + ILEN + 1, 1'b1);
    idle();
    wr(PRIMARY_MASK_OFS, 8'hFF);
    wr(EXT_MASK1_OFS, 8'hFF);
    wr(EXT_MASK2_OFS, 8'h0F);
    wr(AUX_ENABLE_OFS, 8'h1F);
    for (int s = 0; s < SOURCES; s++)
    begin
      pend(s, 1'b1);
      wait_call(s, 1'b0, 20);
      pend(s, 1'b0);
      idle();
    end
    quiet(10);
    pend(4, 1'b1);
    wait_call(4, 1'b0, 20);
    do @(posedge clk_i); while (rdone !== 1'b1);
    #1 check(calls.size(), 0);
    @(posedge clk_i);
    #1 check(calls.size(), 0);
    wait_call(4, 1'b0, WORST_RESPONSE);
    check(lat <= ILEN + DETECT_CYCLES, 1'b1);
    pend(4, 1'b0);
    idle();
    quiet(10);
    wr(PRIMARY_PRIO_OFS, 8'h01);
    rd(PRIMARY_PRIO_OFS);
    check(v, PRIO_RSVD_READ | 8'h01);
    pend(4, 1'b1);
    wait_call(4, 1'b0, 20);
    pend(0, 1'b1);
    wait_call(0, 1'b1, 20);
    check(depth, 2);
    idle();
    pend(0, 1'b1);
    wait_call(0, 1'b1, 20);
    pend(3, 1'b1);
    drain();
    check(calls.size(), 0);
    wait_call(3, 1'b0, 20);
    idle();
    for (int k = 0; k < 2; k++)
    begin
      wr(PRIMARY_MASK_OFS, 8'h7F);
      wr(PRIMARY_PRIO_OFS, k ? 8'h00 : 8'h04);
      wr(PENDING0_OFS, k ? 8'h0C : 8'h06);
      wr(PRIMARY_MASK_OFS, 8'hFF);
      wait_call(2, !k, 20);
      wait_call(k ? 3 : 1, 1'b0, 40);
      idle();
    end
    wr(AUX_ENABLE_OFS, 8'h00);
    pend(5, 1'b1);
    quiet(20);
    wr(AUX_ENABLE_OFS, 8'h01);
    @(posedge clk_i);
    #1 check(request, 1'b1);
    wait_call(5, 1'b0, 20);
    pend(5, 1'b0);
    idle();
    wr(EVENT_MASK_OFS, 8'h01);
    @(posedge clk_i);
    #1 check(irq, 1'b1);
    rd(EVENT_STATUS_OFS);
    check(v[EV_VECTOR], 1'b1);
    repeat (2) @(posedge clk_i);
    #1 check(irq, 1'b0);
    wr(EVENT_MASK_OFS, 8'h00);
    fire(1);
    wait_call(1, 1'b0, 20);
    #1 check(irq, 1'b0);
    idle();
    stop_test();
  end
endmodule
`default_nettype wire
